// file: inc/mps_pkg.sv
/*
 * shared constants and types of the multiphase pwm sequencer
 * assumes a 200 MHz core clock and synchronous, active-high reset
 */
`default_nettype none
package mps_pkg;
    // ==========================================
    // timing
    localparam real CLK_PERIOD_NS = 5.0;
    localparam real POR_DELAY_MS = 2.6;
    localparam int POR_DELAY_CYCLES = int'(POR_DELAY_MS * 1.0e6 / CLK_PERIOD_NS);
    // ==========================================
    // phase configuration
    localparam logic [1:0] PHASES_ONE = 2'h1;
    localparam logic [1:0] PHASES_TWO = 2'h2;
    localparam logic [1:0] PHASES_THREE = 2'h3;
    localparam logic [1:0] SLOT_FIRST = 2'h0;
    localparam logic [1:0] SLOT_SECOND = 2'h1;
    localparam logic [1:0] SLOT_THIRD = 2'h2;
    // ==========================================
    // start-up states
    typedef enum logic [1:0] {
        SU_OFF = 2'b00,
        SU_WAIT = 2'b01,
        SU_RAMP = 2'b10,
        SU_DONE = 2'b11
    } mps_su_state_type;
    // ==========================================
    // per-phase comparator inputs and gate outputs
    typedef struct packed {
        logic slave_ramp_hit;
        logic zero_cross;
    } mps_cmp_type;
    typedef struct packed {
        logic pwm;
        logic low_side_gate;
    } mps_gate_type;
endpackage
`default_nettype wire

// file: rtl/mps_phase_slice.sv
/*
 * one phase slice: pwm on at trigger, off at ramp hit, low side gate control
 * assumes comparator inputs are synchronous to the clock
 */
`default_nettype none
module mps_phase_slice (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic trigger,
    input wire logic reverse_blocking_mode,
    input wire mps_pkg::mps_cmp_type cmp,
    output mps_pkg::mps_gate_type gate
);
    // ==========================================
    // state
    typedef struct packed {
        logic pwm;
        logic zc_block;
    } mps_slice_type;
    mps_slice_type st_reg;
    mps_slice_type st_next;

    always_comb
    begin
        st_next = st_reg;
        if (!enable)
        begin
            st_next.pwm = 1'b0;
            st_next.zc_block = 1'b0;
        end
        else if (st_reg.pwm)
        begin
            // ramp hit ends the pulse; a pulse end also lifts the block
            if (cmp.slave_ramp_hit)
            begin
                st_next.pwm = 1'b0;
                st_next.zc_block = 1'b0;
            end
        end
        else if (trigger)
        begin
            st_next.pwm = 1'b1;
        end
        else if (reverse_blocking_mode && cmp.zero_cross)
        begin
            st_next.zc_block = 1'b1;
        end
        if (!reverse_blocking_mode)
        begin
            st_next.zc_block = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // low side held off while high side on (no shoot-through) or while blocked
    assign gate.pwm = st_reg.pwm;
    assign gate.low_side_gate = enable && !st_reg.pwm && !st_reg.zc_block;

    // ==========================================
    // checks
    property p_pulse_ends;
        @(posedge clk) disable iff (rst)
        (st_reg.pwm && cmp.slave_ramp_hit) |=> !st_reg.pwm;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse not ended at ramp hit");

    property p_pulse_starts;
        @(posedge clk) disable iff (rst)
        (enable && !st_reg.pwm && trigger) |=> st_reg.pwm;
    endproperty
    a_pulse_starts: assert property (p_pulse_starts) else $error("pulse not started at trigger");

    property p_zc_off;
        @(posedge clk) disable iff (rst)
        (enable && reverse_blocking_mode && !st_reg.pwm && !trigger && cmp.zero_cross)
            |=> !gate.low_side_gate;
    endproperty
    a_zc_off: assert property (p_zc_off) else $error("low side not off at zero cross");

    // block is dropped when the slice is disabled or the mode is left
    sequence s_blocked;
        st_reg.zc_block && !st_reg.pwm && enable && reverse_blocking_mode;
    endsequence
    property p_block_holds;
        @(posedge clk) disable iff (rst)
        (s_blocked ##1 (enable && reverse_blocking_mode && !st_reg.pwm)) |-> !gate.low_side_gate;
    endproperty
    a_block_holds: assert property (p_block_holds) else $error("low side back on before pulse end");
endmodule
`default_nettype wire

// file: rtl/mps_sequencer.sv
/*
 * multiphase pwm sequencer top: master clock, phase rotation, start-up
 * assumes all inputs synchronous to REF_CLK; analog comparators are external
 */
// Behaviour
// - the primary regulator runs one, two or three phases, the secondary always one with the same logic.
// - each master ramp hit of the error level while supply good and the on request are high gives one single master clock pulse and restarts the ramp.
// - with three phases successive master pulses go to phases one, two, three in rotation.
// - with two phases master pulses alternate between phases one and two and phase three gets none.
// - with one phase every master pulse goes to phase one as its trigger.
// - a phase starts its pwm pulse on its trigger.
// - a phase ends its pwm pulse when its slave ramp reaches the window threshold.
// - in reverse blocking mode the low side gate goes off at the zero crossing.
// - start-up begins only while supply good holds and the regulator on request is high.
// - during start-up the target level ramps digitally from zero to the commanded voltage.
// - at ramp end power good goes high and the active-low alert goes low.
// - with the on request held high, soft-start begins 2.6 ms after the supply good edge.
`default_nettype none
module mps_sequencer #(
    parameter int TARGET_WIDTH = 8,
    parameter int POR_DELAY_CYCLES = mps_pkg::POR_DELAY_CYCLES,
    parameter int RAMP_STEP_CYCLES = 16
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SUPPLY_GOOD,
    input wire logic PRI_REGULATOR_ON_REQUEST,
    input wire logic SEC_REGULATOR_ON_REQUEST,
    input wire logic [1:0] PRI_PHASE_COUNT,
    input wire logic REVERSE_BLOCKING_MODE,
    input wire logic [TARGET_WIDTH-1:0] PRI_SET_TARGET_VOLTAGE_CMD,
    input wire logic [TARGET_WIDTH-1:0] SEC_SET_TARGET_VOLTAGE_CMD,
    input wire logic PRI_MASTER_RAMP_HIT,
    input wire logic SEC_MASTER_RAMP_HIT,
    input wire mps_pkg::mps_cmp_type [3:0] PHASE_CMP,
    output mps_pkg::mps_gate_type [3:0] PHASE_GATE,
    output logic PRI_MASTER_RAMP_RESTART,
    output logic SEC_MASTER_RAMP_RESTART,
    output logic [2:0] PHASE_TRIGGER_1TO3,
    output logic [TARGET_WIDTH-1:0] PRI_TARGET_LEVEL,
    output logic [TARGET_WIDTH-1:0] SEC_TARGET_LEVEL,
    output logic PRI_POWER_GOOD_OUT,
    output logic SEC_POWER_GOOD_OUT,
    output logic PRI_ALERT_N,
    output logic SEC_ALERT_N
);
    localparam int CW = $clog2(POR_DELAY_CYCLES + 1);
    localparam int SW = $clog2(RAMP_STEP_CYCLES + 1);

    // refused at elaboration: zero-width counters cannot be built
    if (TARGET_WIDTH < 1 || POR_DELAY_CYCLES < 1 || RAMP_STEP_CYCLES < 1)
    begin : g_bad_param
        $error("mps_sequencer: bad parameter");
    end

    // ==========================================
    // state of one regulator and whole block
    typedef struct packed {
        mps_pkg::mps_su_state_type su;
        logic [CW-1:0] por_cnt;
        logic [SW-1:0] step_cnt;
        logic [TARGET_WIDTH-1:0] level;
        logic hit_seen;
        logic mclk;
    } mps_vr_type;
    typedef struct packed {
        mps_vr_type pri;
        mps_vr_type sec;
        logic [1:0] slot;
    } mps_state_type;
    mps_state_type st_reg;
    mps_state_type st_next;

    // one regulator's start-up and master clock step; shared by both
    function automatic mps_vr_type vr_step(input mps_vr_type v, input logic on_req,
                                           input logic supply, input logic ramp_hit,
                                           input logic [TARGET_WIDTH-1:0] cmd);
        mps_vr_type n;
        n = v;
        // single pulse per hit: edge of the comparator level
        n.mclk = ramp_hit && !v.hit_seen;
        n.hit_seen = ramp_hit;
        if (!supply || !on_req)
        begin
            n.su = mps_pkg::SU_OFF;
            n.level = '0;
            n.step_cnt = '0;
            n.mclk = 1'b0;
        end
        else
        begin
            case (v.su)
                mps_pkg::SU_OFF:
                    n.su = mps_pkg::SU_WAIT;
                mps_pkg::SU_WAIT:
                begin
                    // counted from supply good; a late on request skips the rest
                    if (v.por_cnt >= CW'(POR_DELAY_CYCLES - 1))
                        n.su = mps_pkg::SU_RAMP;
                end
                mps_pkg::SU_RAMP:
                begin
                    // one lsb per step so the ramp is slew limited
                    if (v.level >= cmd)
                    begin
                        n.level = cmd;
                        n.su = mps_pkg::SU_DONE;
                    end
                    else if (v.step_cnt >= SW'(RAMP_STEP_CYCLES - 1))
                    begin
                        n.step_cnt = '0;
                        n.level = v.level + 1'b1;
                    end
                    else
                        n.step_cnt = v.step_cnt + 1'b1;
                end
                mps_pkg::SU_DONE:
                    n.level = cmd;
                default:
                    n.su = mps_pkg::SU_OFF;
            endcase
        end
        if (!supply)
            n.por_cnt = '0;
        else if (v.por_cnt < CW'(POR_DELAY_CYCLES - 1))
            n.por_cnt = v.por_cnt + 1'b1;
        return n;
    endfunction

    logic pri_run;
    logic sec_run;
    logic [1:0] phases;
    logic [2:0] trig;

    assign pri_run = st_reg.pri.su != mps_pkg::SU_OFF && st_reg.pri.su != mps_pkg::SU_WAIT;
    assign sec_run = st_reg.sec.su != mps_pkg::SU_OFF && st_reg.sec.su != mps_pkg::SU_WAIT;
    // zero phases is not a legal strap; treat it as one
    assign phases = (PRI_PHASE_COUNT == 2'h0) ? mps_pkg::PHASES_ONE : PRI_PHASE_COUNT;

    // ==========================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        st_next.pri = vr_step(st_reg.pri, PRI_REGULATOR_ON_REQUEST, SUPPLY_GOOD,
                              PRI_MASTER_RAMP_HIT, PRI_SET_TARGET_VOLTAGE_CMD);
        st_next.sec = vr_step(st_reg.sec, SEC_REGULATOR_ON_REQUEST, SUPPLY_GOOD,
                              SEC_MASTER_RAMP_HIT, SEC_SET_TARGET_VOLTAGE_CMD);
        if (!pri_run || phases == mps_pkg::PHASES_ONE)
            st_next.slot = mps_pkg::SLOT_FIRST;
        else if (st_reg.pri.mclk)
        begin
            if (phases == mps_pkg::PHASES_TWO)
                st_next.slot = (st_reg.slot == mps_pkg::SLOT_FIRST) ? mps_pkg::SLOT_SECOND
                                                                    : mps_pkg::SLOT_FIRST;
            else
                st_next.slot = (st_reg.slot == mps_pkg::SLOT_THIRD) ? mps_pkg::SLOT_FIRST
                                                                    : st_reg.slot + 2'h1;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            st_reg <= '0;
        end
        else
            st_reg <= st_next;
    end

    // ==========================================
    // trigger distribution
    always_comb
    begin
        trig = 3'h0;
        if (pri_run && st_reg.pri.mclk)
            trig[st_reg.slot] = 1'b1;
    end
    assign PHASE_TRIGGER_1TO3 = trig;
    assign PRI_MASTER_RAMP_RESTART = st_reg.pri.mclk;
    assign SEC_MASTER_RAMP_RESTART = st_reg.sec.mclk;

    // slots 0..2 primary phases, slot 3 the secondary single phase
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_slice
            logic en;
            logic tr;
            assign en = (g == 3) ? sec_run : (pri_run && g < int'(phases));
            assign tr = (g == 3) ? (sec_run && st_reg.sec.mclk) : trig[g];
            mps_phase_slice u_slice (
                .clk(REF_CLK),
                .rst(RST),
                .enable(en),
                .trigger(tr),
                .reverse_blocking_mode(REVERSE_BLOCKING_MODE),
                .cmp(PHASE_CMP[g]),
                .gate(PHASE_GATE[g])
            );
        end
    endgenerate

    assign PRI_TARGET_LEVEL = st_reg.pri.level;
    assign SEC_TARGET_LEVEL = st_reg.sec.level;
    assign PRI_POWER_GOOD_OUT = st_reg.pri.su == mps_pkg::SU_DONE;
    assign SEC_POWER_GOOD_OUT = st_reg.sec.su == mps_pkg::SU_DONE;
    assign PRI_ALERT_N = st_reg.pri.su != mps_pkg::SU_DONE;
    assign SEC_ALERT_N = st_reg.sec.su != mps_pkg::SU_DONE;

    // ==========================================
    // checks
    property p_single_pulse;
        @(posedge REF_CLK) disable iff (RST)
        st_reg.pri.mclk |=> !st_reg.pri.mclk;
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("master pulse longer than one cycle");

    sequence s_rot3_start;
        pri_run && phases == mps_pkg::PHASES_THREE && trig[0];
    endsequence
    property p_rot3;
        @(posedge REF_CLK) disable iff (RST)
        s_rot3_start |-> !trig[2] until_with trig[1];
    endproperty
    a_rot3: assert property (p_rot3) else $error("three phase rotation out of order");

    property p_two_no3;
        @(posedge REF_CLK) disable iff (RST)
        (phases == mps_pkg::PHASES_TWO) |-> !trig[2];
    endproperty
    a_two_no3: assert property (p_two_no3) else $error("phase three triggered in two phase mode");

    property p_one_only;
        @(posedge REF_CLK) disable iff (RST)
        (pri_run && phases == mps_pkg::PHASES_ONE && st_reg.pri.mclk) |-> trig == 3'h1;
    endproperty
    a_one_only: assert property (p_one_only) else $error("single phase pulse not on phase one");

    property p_gated;
        @(posedge REF_CLK) disable iff (RST)
        (!SUPPLY_GOOD || !PRI_REGULATOR_ON_REQUEST) |=> st_reg.pri.su == mps_pkg::SU_OFF;
    endproperty
    a_gated: assert property (p_gated) else $error("start-up without supply or on request");

    property p_ramp_mono;
        @(posedge REF_CLK) disable iff (RST)
        // a dropped supply or on request, or a lowered command, may pull the level down
        (st_reg.pri.su == mps_pkg::SU_RAMP && SUPPLY_GOOD && PRI_REGULATOR_ON_REQUEST
            && PRI_SET_TARGET_VOLTAGE_CMD >= st_reg.pri.level)
            |=> st_reg.pri.level >= $past(st_reg.pri.level);
    endproperty
    a_ramp_mono: assert property (p_ramp_mono) else $error("target ramp went down");

    property p_good_alert;
        @(posedge REF_CLK) disable iff (RST)
        // level follows the command one cycle late
        PRI_POWER_GOOD_OUT |-> !PRI_ALERT_N && PRI_TARGET_LEVEL == $past(PRI_SET_TARGET_VOLTAGE_CMD);
    endproperty
    a_good_alert: assert property (p_good_alert) else $error("power good without alert or level");

    property p_por_wait;
        @(posedge REF_CLK) disable iff (RST)
        (st_reg.pri.su == mps_pkg::SU_WAIT ##1 st_reg.pri.su == mps_pkg::SU_RAMP)
            |-> $past(st_reg.pri.por_cnt) == CW'(POR_DELAY_CYCLES - 1);
    endproperty
    a_por_wait: assert property (p_por_wait) else $error("soft-start before power-on delay");
endmodule
`default_nettype wire

// file: test/mps_power_stage.sv
/*
 * power stage model: slave ramp and zero-cross comparators per phase
 * assumes gates change just after rising edges of clk
 */
`default_nettype none
module mps_power_stage (
    input wire logic clk,
    input wire logic [3:0] on_len,
    input wire logic [3:0] zc_len,
    input wire mps_pkg::mps_gate_type [3:0] gate,
    output var mps_pkg::mps_cmp_type [3:0] cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hi [4] = '{default: 4'h0};
    logic [3:0] lo [4] = '{default: 4'h0};
    // ====================
    // on time and decay counts; unknown before reset counts as on
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            hi[i] <= (gate[i].pwm !== 1'b0) ? hi[i] + 4'h1 : 4'h0;
            if (gate[i].pwm !== 1'b0)
                lo[i] <= 4'h0;
            else if (gate[i].low_side_gate === 1'b1 && lo[i] != 4'hf)
                lo[i] <= lo[i] + 4'h1;
        end
    end
    // ====================
    // zero seen only while low side conducts; node rings off once it opens
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            cmp[i].slave_ramp_hit = gate[i].pwm === 1'b1 && hi[i] >= on_len;
            cmp[i].zero_cross = gate[i].pwm === 1'b0 && gate[i].low_side_gate === 1'b1 && zc_len != 4'h0
                && lo[i] >= zc_len;
        end
    end
endmodule
`default_nettype wire

// file: test/mps_sequencer_tb.sv
/*
 * self-checking bench of the multiphase pwm sequencer
 * assumes the power stage model closes the comparator loop
 */
`default_nettype none
module mps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic supply_good = 1'b0;
    logic pri_on = 1'b1;
    logic sec_on = 1'b0;
    logic [1:0] pri_count = 2'h3;
    logic rbm = 1'b0;
    logic pri_hit = 1'b0;
    logic sec_hit = 1'b0;
    logic [7:0] pri_cmd = 8'h05;
    logic [7:0] sec_cmd = 8'h03;
    logic [3:0] on_len = 4'h1;
    logic [3:0] zc_len = 4'h0;
    mps_pkg::mps_cmp_type [3:0] cmp;
    mps_pkg::mps_gate_type [3:0] gate;
    logic pri_restart;
    logic sec_restart;
    logic [2:0] trigger;
    logic [7:0] pri_level;
    logic [7:0] sec_level;
    logic pri_pg;
    logic sec_pg;
    logic pri_alert_n;
    logic sec_alert_n;
    int n_mismatch = 0;
    int n_checks = 0;

    mps_sequencer #(.TARGET_WIDTH(8), .POR_DELAY_CYCLES(POR), .RAMP_STEP_CYCLES(2)) mps_sequencer_i (
        .REF_CLK(clk), .RST(rst), .SUPPLY_GOOD(supply_good), .PRI_REGULATOR_ON_REQUEST(pri_on),
        .SEC_REGULATOR_ON_REQUEST(sec_on), .PRI_PHASE_COUNT(pri_count), .REVERSE_BLOCKING_MODE(rbm),
        .PRI_SET_TARGET_VOLTAGE_CMD(pri_cmd), .SEC_SET_TARGET_VOLTAGE_CMD(sec_cmd),
        .PRI_MASTER_RAMP_HIT(pri_hit), .SEC_MASTER_RAMP_HIT(sec_hit), .PHASE_CMP(cmp), .PHASE_GATE(gate),
        .PRI_MASTER_RAMP_RESTART(pri_restart), .SEC_MASTER_RAMP_RESTART(sec_restart),
        .PHASE_TRIGGER_1TO3(trigger), .PRI_TARGET_LEVEL(pri_level), .SEC_TARGET_LEVEL(sec_level),
        .PRI_POWER_GOOD_OUT(pri_pg), .SEC_POWER_GOOD_OUT(sec_pg), .PRI_ALERT_N(pri_alert_n),
        .SEC_ALERT_N(sec_alert_n));
    mps_power_stage mps_power_stage_i (.clk(clk), .on_len(on_len), .zc_len(zc_len), .gate(gate), .cmp(cmp));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ====================
    // hit held four cycles: a held level must not give a second pulse
    task automatic fire(input logic sec, output logic [2:0] trig, output logic [3:0] pwm, output logic [2:0] nres);
        @(posedge clk);
        if (sec)
            sec_hit <= 1'b1;
        else
            pri_hit <= 1'b1;
        trig = 3'h0;
        pwm = 4'h0;
        nres = 3'h0;
        repeat (4)
        begin
            @(negedge clk);
            trig |= trigger;
            nres += 3'(sec ? sec_restart : pri_restart);
            for (int i = 0; i < 4; i++)
                pwm[i] |= gate[i].pwm;
        end
        @(posedge clk);
        pri_hit <= 1'b0;
        sec_hit <= 1'b0;
        repeat (on_len + 6) @(negedge clk);
        check("pwm_end", 8'h0, {4'h0, gate[3].pwm, gate[2].pwm, gate[1].pwm, gate[0].pwm});
    endtask

    task automatic t_startup();
        logic [7:0] prev;
        logic [2:0] trig;
        logic [3:0] pwm;
        logic [2:0] nres;
        int n;
        prev = 8'h0;
        repeat (30) @(negedge clk);
        check("pg_no_supply", 8'h0, pri_pg);
        fire(1'b1, trig, pwm, nres);
        check("sec_off_restart", 8'h0, nres);
        check("sec_off_pwm", 8'h0, pwm);
        @(posedge clk);
        supply_good <= 1'b1;
        for (n = 1; n < 100 && pri_pg !== 1'b1; n++)
        begin
            @(negedge clk);
            check("ramp_step", 8'h1, pri_level >= prev && pri_level <= pri_cmd);
            prev = pri_level;
        end
        check("por_delay", 8'h1, n > POR + 8 && n < POR + 24);
        check("pri_level", pri_cmd, pri_level);
        check("pri_alert", 8'h0, pri_alert_n);
        check("sec_pg_off", 8'h0, sec_pg);
        @(posedge clk);
        sec_on <= 1'b1;
        for (n = 0; n < 40 && sec_pg !== 1'b1; n++)
            @(negedge clk);
        check("sec_level", sec_cmd, sec_level);
        check("sec_pg", 8'h1, sec_pg);
        check("sec_alert", 8'h0, sec_alert_n);
    endtask

    task automatic t_rotate(input logic [1:0] cnt, input logic [3:0] len);
        logic [2:0] trig;
        logic [3:0] pwm;
        logic [2:0] nres;
        logic [2:0] exp;
        int n;
        n = int'(cnt);
        exp = 3'h0;
        @(posedge clk);
        pri_count <= cnt;
        on_len <= len;
        for (int k = 0; k < 6; k++)
        begin
            fire(1'b0, trig, pwm, nres);
            if (k == 0)
            begin
                check("slot_first", 8'h1, $onehot(trig) && (4'(trig) >> n) == 4'h0);
                exp = trig;
            end
            check("trigger", exp, trig);
            check("pwm_phase", {5'h0, exp}, pwm);
            check("restart", 8'h1, nres);
            exp = ((4'(exp) << 1) >> n) != 4'h0 ? 3'h1 : exp << 1;
        end
        fire(1'b1, trig, pwm, nres);
        check("sec_trigger", 8'h0, trig);
        check("sec_restart", 8'h1, nres);
        check("sec_pwm", 8'h8, pwm);
    endtask

    // ====================
    // low side with and without blocking, then regulator shut off
    task automatic t_blocking();
        logic [2:0] trig;
        logic [3:0] pwm;
        logic [2:0] nres;
        logic seen;
        int n;
        @(posedge clk);
        zc_len <= 4'h3;
        repeat (10) @(negedge clk);
        check("ls_mode_off", 8'h1, gate[0].low_side_gate);
        @(posedge clk);
        rbm <= 1'b1;
        repeat (2) @(negedge clk);
        check("ls_zero_cross", 8'h0, gate[0].low_side_gate);
        seen = 1'b0;
        repeat (8)
        begin
            @(negedge clk);
            seen |= gate[0].low_side_gate;
        end
        check("ls_held_off", 8'h0, seen);
        @(posedge clk);
        pri_hit <= 1'b1;
        for (n = 0; n < 8 && gate[0].pwm !== 1'b1; n++)
            @(negedge clk);
        for (n = 0; n < 12 && gate[0].pwm !== 1'b0; n++)
            @(negedge clk);
        seen = gate[0].low_side_gate;
        @(negedge clk);
        seen |= gate[0].low_side_gate;
        check("ls_after_pulse", 8'h1, seen);
        @(posedge clk);
        pri_hit <= 1'b0;
        pri_on <= 1'b0;
        repeat (2) @(negedge clk);
        check("off_level", 8'h0, pri_level);
        check("off_pg", 8'h0, pri_pg);
        check("off_alert", 8'h1, pri_alert_n);
        fire(1'b0, trig, pwm, nres);
        check("off_restart", 8'h0, nres);
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_startup();
        t_rotate(2'h3, 4'h1);
        t_rotate(2'h2, 4'h6);
        t_rotate(2'h1, 4'h1);
        t_blocking();
        final_report();
    end

    // ====================
    // watchdog: the run needs well under 5000 cycles
    initial
    begin
        #100000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
